// *** rtl/ptp_controller.sv ***
`timescale 1ns/1ps
module ptp_controller #(
    parameter int unsigned PERIOD = ptp_pkg::PERIOD_CYCLES,
    parameter int unsigned HIGH_MAX = ptp_pkg::MAX_HIGH,
    parameter int unsigned EVENTS = ptp_pkg::LIMIT_EVENTS,
    parameter int unsigned HICCUP = ptp_pkg::HICCUP_CYCLES
) (
    input wire logic clock,
    input wire logic nrst,
    ptp_link_if.controller link,
    input wire logic supplies_ok,
    input wire logic hiccup_mode,
    input wire logic [11:0] limit_set,
    output logic running,
    output logic latched_off
);
    ptp_pkg::ptp_state_t state;
    logic [ptp_pkg::CNT_W-1:0] phase;
    logic [ptp_pkg::CNT_W-1:0] high_time;
    logic [ptp_pkg::CNT_W-1:0] events;
    logic [ptp_pkg::CNT_W-1:0] wait_cnt;
    logic flag_q;
    logic period_end;
    logic flag_rise;
    assign period_end = (phase == 8'(PERIOD - 1));
    assign flag_rise = link.overcurrent_flag && !flag_q;
    // fixed period counter keeps frequency constant while duty ramps
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            phase <= 8'h00;
            flag_q <= 1'b1;
        end else begin
            phase <= period_end ? 8'h00 : 8'(phase + 8'h01);
            flag_q <= link.overcurrent_flag;
        end
    end
    // pulse output registered from phase and duty
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            link.pulse_train <= 1'b0;
        end else begin
            link.pulse_train <= (state == ptp_pkg::PTP_SOFT || state == ptp_pkg::PTP_RUN)
                && (phase < high_time);
        end
    end
    assign link.limit_threshold = limit_set;
    // sequencing: wait, soft-start, run, hiccup or latch off
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= ptp_pkg::PTP_WAIT;
            high_time <= 8'h00;
            events <= 8'h00;
            wait_cnt <= 8'h00;
            latched_off <= 1'b0;
        end else begin
            case (state)
                ptp_pkg::PTP_WAIT: begin
                    high_time <= 8'h00;
                    if (supplies_ok && !link.overcurrent_flag && !latched_off
                        && period_end) begin
                        state <= ptp_pkg::PTP_SOFT;
                    end
                end
                ptp_pkg::PTP_SOFT, ptp_pkg::PTP_RUN: begin
                    if (flag_rise) begin
                        if (events == 8'(EVENTS - 1)) begin
                            events <= 8'h00;
                            wait_cnt <= 8'h00;
                            high_time <= 8'h00;
                            if (hiccup_mode) begin
                                state <= ptp_pkg::PTP_HICCUP;
                            end else begin
                                state <= ptp_pkg::PTP_WAIT;
                                latched_off <= 1'b1;
                            end
                        end else begin
                            events <= 8'(events + 8'h01);
                        end
                    end else if (period_end && state == ptp_pkg::PTP_SOFT) begin
                        if (high_time >= 8'(HIGH_MAX)) begin
                            state <= ptp_pkg::PTP_RUN;
                        end else begin
                            high_time <= 8'(high_time + 8'(ptp_pkg::SOFT_STEP));
                        end
                    end
                end
                ptp_pkg::PTP_HICCUP: begin
                    wait_cnt <= 8'(wait_cnt + 8'h01);
                    // restart by soft-start; waiting for flag low would hang,
                    // the flag only clears on a pulse edge
                    if (wait_cnt == 8'(HICCUP - 1)) begin
                        state <= ptp_pkg::PTP_SOFT;
                    end
                end
                default: begin
                    state <= ptp_pkg::PTP_WAIT;
                end
            endcase
        end
    end
    assign running = (state == ptp_pkg::PTP_RUN);
endmodule : ptp_controller

// *** rtl/ptp_pkg.sv ***
package ptp_pkg;
    // comparator inputs as unsigned millivolt codes
    localparam int unsigned MV_W = 12;
    localparam logic [MV_W-1:0] TRIP_OFFSET_MV = 12'h019; // 25 mV below threshold
    localparam logic [MV_W-1:0] LIMIT_DEFAULT_MV = 12'h1f4; // 500 mV open-pin value
    // controller timing, in cycles of the system clock
    localparam int unsigned PERIOD_CYCLES = 20; // 2 MHz at 40 MHz clock
    localparam int unsigned SOFT_STEP = 1;
    localparam int unsigned MAX_HIGH = 9; // high cycles in steady state
    localparam int unsigned HICCUP_CYCLES = 200;
    localparam int unsigned LIMIT_EVENTS = 4;
    localparam int unsigned CNT_W = 8;
    typedef enum logic [3:0] {
        PTP_WAIT = 4'h1,
        PTP_SOFT = 4'h2,
        PTP_RUN = 4'h4,
        PTP_HICCUP = 4'h8
    } ptp_state_t;
endpackage : ptp_pkg

// *** rtl/ptp_link_if.sv ***
`timescale 1ns/1ps
interface ptp_link_if;
    logic pulse_train; // controller to device
    logic overcurrent_flag; // device to controller
    logic [11:0] limit_threshold; // controller-set threshold, millivolts
    modport device (input pulse_train, input limit_threshold, output overcurrent_flag);
    modport controller (output pulse_train, output limit_threshold, input overcurrent_flag);
endinterface : ptp_link_if

// *** rtl/ptp_device.sv ***
`timescale 1ns/1ps
module ptp_device (
    input wire logic clock,
    input wire logic nrst,
    ptp_link_if.device link,
    input wire logic ref_good,
    input wire logic pwm_trip,
    input wire logic [11:0] sense_mv,
    output logic drive_a,
    output logic drive_b
);
    logic pulse_q;
    logic steer_b;
    logic first_done;
    logic cut;
    logic flag;
    logic rise;
    logic limit_trip;
    logic live_steer;
    logic live_cut;
    logic started;
    logic armed;
    // threshold minus offset, guarded against underflow
    logic [11:0] trip_level;
    assign trip_level = (link.limit_threshold > ptp_pkg::TRIP_OFFSET_MV) ?
        12'(link.limit_threshold - ptp_pkg::TRIP_OFFSET_MV) : 12'h000;
    assign limit_trip = ref_good && (sense_mv > trip_level);
    assign rise = ref_good && link.pulse_train && !pulse_q;
    // what an accepted edge is about to load, so its first drive cycle already
    // uses the new steering and a cleared cut rather than last cycle's
    assign live_steer = rise ? (first_done && !steer_b) : steer_b;
    assign live_cut = cut && !rise;
    assign started = first_done || rise;
    // edge detector history; reset keeps a held-high input from looking like an edge
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pulse_q <= 1'b1;
        end else begin
            pulse_q <= link.pulse_train;
        end
    end
    // steering toggles per accepted edge, first edge to a
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            steer_b <= 1'b0;
            first_done <= 1'b0;
        end else if (!ref_good) begin
            steer_b <= 1'b0;
            first_done <= 1'b0;
        end else if (rise) begin
            first_done <= 1'b1;
            steer_b <= first_done ? !steer_b : 1'b0;
        end
    end
    // cut latch ends the pulse early until next edge; trip in same cycle as edge wins
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cut <= 1'b1;
        end else if (!ref_good) begin
            cut <= 1'b1;
        end else if (pwm_trip || limit_trip) begin
            cut <= 1'b1;
        end else if (rise) begin
            cut <= 1'b0;
        end
    end
    // flag high from reset until reference good, released once, then latched per trip;
    // a trip before the first edge must stay latched, so release is a one-shot
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            flag <= 1'b1;
            armed <= 1'b0;
        end else if (!ref_good) begin
            flag <= 1'b1;
            armed <= 1'b0;
        end else if (limit_trip) begin
            flag <= 1'b1;
            armed <= 1'b1;
        end else if (rise || !armed) begin
            flag <= 1'b0;
            armed <= 1'b1;
        end
    end
    assign link.overcurrent_flag = flag;
    // drives registered; a trip removes drive on the next edge, combinational gating
    // would be faster but glitch on comparator noise
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            drive_a <= 1'b0;
            drive_b <= 1'b0;
        end else begin
            drive_a <= 1'b0;
            drive_b <= 1'b0;
            if (ref_good && link.pulse_train && started && !live_cut
                && !pwm_trip && !limit_trip) begin
                drive_a <= !live_steer;
                drive_b <= live_steer;
            end
        end
    end
endmodule : ptp_device

// *** verification/ptp_props.sv ***
`timescale 1ns/1ps
module ptp_props (
    input wire logic clock,
    input wire logic nrst,
    input wire logic pulse_train,
    input wire logic overcurrent_flag,
    input wire logic [11:0] limit_threshold,
    input wire logic ref_good,
    input wire logic pwm_trip,
    input wire logic [11:0] sense_mv,
    input wire logic drive_a,
    input wire logic drive_b
);
    logic lim;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // floored so a low threshold cannot wrap
    assign lim = sense_mv > ((limit_threshold > ptp_pkg::TRIP_OFFSET_MV) ?
        limit_threshold - ptp_pkg::TRIP_OFFSET_MV : 12'h000);
    sequence s_edge;
        $rose(pulse_train) && ref_good;
    endsequence
    // outputs follow their cause one cycle later
    AST_EDGE_ON: assert property (s_edge ##0 !lim && !pwm_trip |=> drive_a || drive_b)
        else $error("no pulse");
    AST_LOW_OFF: assert property (!pulse_train |=> !drive_a && !drive_b)
        else $error("drive while low");
    AST_NO_REF: assert property (!ref_good |=> !drive_a && !drive_b && overcurrent_flag)
        else $error("ref low");
    AST_PWM_CUT: assert property (pwm_trip |=> !drive_a && !drive_b) else $error("pwm");
    AST_LIM_CUT: assert property (lim |=> overcurrent_flag && !drive_a && !drive_b)
        else $error("limit");
    AST_FLAG_CLR: assert property (s_edge ##0 !lim |=> !overcurrent_flag)
        else $error("flag kept");
    AST_FLAG_HOLD: assert property (overcurrent_flag && ref_good && $past(ref_good)
        && !$rose(pulse_train) |=> overcurrent_flag) else $error("flag lost");
    AST_EXCL: assert property (!(drive_a && drive_b)) else $error("both drives");
endmodule : ptp_props

// *** verification/tb.sv ***
`timescale 1ns/1ps
module tb;
    logic clock = 1'b0, nrst = 1'b0, ref_good = 1'b0, pwm_trip = 1'b0, hiccup_mode = 1'b1;
    logic supplies_ok = 1'b1, drive_a, drive_b, latched_off, lt, pv, pt, running;
    logic [11:0] sense_mv = 12'h000, limit_set = ptp_pkg::LIMIT_DEFAULT_MV;
    int mismatches, tests_run, nrise, i, seed = 32'hc048;
    ptp_link_if link ();
    ptp_device ptp_device_inst (.clock, .nrst, .link, .ref_good, .pwm_trip, .sense_mv, .drive_a,
        .drive_b);
    ptp_controller #(.PERIOD(10), .HIGH_MAX(4), .EVENTS(2), .HICCUP(20)) ptp_controller_inst (
        .clock, .nrst, .link, .supplies_ok, .hiccup_mode, .limit_set, .running, .latched_off);
    ptp_props ptp_props_inst (.clock, .nrst, .pulse_train(link.pulse_train),
        .overcurrent_flag(link.overcurrent_flag), .limit_threshold(link.limit_threshold),
        .ref_good, .pwm_trip, .sense_mv, .drive_a, .drive_b);
    task automatic check(input logic seen, input logic exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // expected trip: sense above threshold less the fixed offset, floored at zero
    function automatic logic trip_expected(input logic [11:0] level, input logic [11:0] limit);
        if (limit > ptp_pkg::TRIP_OFFSET_MV) begin
            return level > 12'(limit - ptp_pkg::TRIP_OFFSET_MV);
        end
        return level != 12'h000;
    endfunction : trip_expected
    task automatic finish_test();
        $display("errors %0d of %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    // clean stretch: first pulse on drive a, then alternating
    task automatic run_quiet();
        nrise = 0;
        repeat (150) begin
            pv = drive_a | drive_b;
            @(negedge clock);
            if ((drive_a | drive_b) && !pv) begin
                check(drive_a, !nrise[0]);
                nrise++;
            end
        end
        check(nrise > 5, 1'b1);
        check(running, 1'b1);
    endtask : run_quiet
    // 25 ns clock
    initial forever #12.5 clock = ~clock;
    // guard at some twenty times the planned run
    initial begin
        #(25 * 20000);
        mismatches++;
        finish_test();
    end
    // inputs move on falling edges only
    initial begin
        repeat (12) @(negedge clock);
        check(link.overcurrent_flag, 1'b1);
        nrst = 1'b1;
        ref_good = 1'b1;
        repeat (2) @(negedge clock);
        check(link.overcurrent_flag, 1'b0);
        run_quiet();
        // random levels and trips; thresholds stay above the offset
        for (i = 0; i < 400; i++) begin
            lt = trip_expected(sense_mv, limit_set);
            pt = pwm_trip;
            @(negedge clock);
            if (lt) check(link.overcurrent_flag & !(drive_a | drive_b), 1'b1);
            if (pt) check(drive_a | drive_b, 1'b0);
            sense_mv = 12'({$random(seed)} % 1100);
            limit_set = 12'(250 + {$random(seed)} % 751);
            pwm_trip = ($random(seed) & 7) == 0;
            // corners: exactly at the trip level, then one code above it
            if (i % 40 == 0) sense_mv = limit_set - ptp_pkg::TRIP_OFFSET_MV;
            if (i % 40 == 1) sense_mv = limit_set - ptp_pkg::TRIP_OFFSET_MV + 12'h001;
        end
        check(latched_off, 1'b0);
        sense_mv = 12'h000;
        pwm_trip = 1'b0;
        ref_good = 1'b0;
        repeat (15) @(negedge clock);
        check(drive_a | drive_b | !link.overcurrent_flag, 1'b0);
        ref_good = 1'b1;
        run_quiet();
        // short overloads with hiccup off end in latch-off
        hiccup_mode = 1'b0;
        for (i = 0; i < 300; i++) begin
            @(negedge clock);
            sense_mv = (i % 7 < 2) ? 12'hfff : 12'h000;
        end
        check(latched_off, 1'b1);
        finish_test();
    end
endmodule : tb
